//--- clk_sync_device.sv
// Clock device end: channel dividers, sync sequencing, resets, output drivers
//
// Local design decisions: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module clk_sync_device #(
    parameter int          POR_SYNC = clk_sync_pkg::POR_SYNC_CYC,
    parameter int          POR_RUN  = clk_sync_pkg::POR_RUN_CYC,
    parameter int          RST_NV   = clk_sync_pkg::RST_NV_CYC,
    parameter logic [19:0] NV_PHASE = 20'h00000
) (
    input  wire logic        clock,
    input  wire logic        rst,
    clk_sync_if.device       link,
    output logic [11:0]      diff_out,
    output logic [11:0]      diff_oe_n,
    output logic [11:0]      se_a,
    output logic [11:0]      se_a_oe_n,
    output logic [11:0]      se_b,
    output logic [11:0]      se_b_oe_n,
    output logic [3:0]       ch_running
);
    localparam int NCH = clk_sync_pkg::NUM_CH;
    localparam int NOUT = clk_sync_pkg::NUM_OUT;

    if (POR_SYNC < 1 || POR_RUN <= POR_SYNC || RST_NV < 1 || POR_RUN > 2**24 - 1) begin : g_chk
        $error("Bad reset timing parameters");
    end

    function automatic logic in_block(input logic [11:0] a, input logic [11:0] base, input int n);
        return (a >= base) && (a < base + 12'(n));
    endfunction

    // Pin synchronizers: sync, reset, sleep, config source
    logic [3:0] pin_s1_reg, pin_s2_reg, pin_s3_reg, pin_lvl_reg;
    logic [3:0] pin_raw;
    assign pin_raw = {link.cfg_src, link.sleep_n, link.reset_n, link.sync_n};
    always_ff @(posedge clock) begin
        if (rst) begin
            pin_s1_reg  <= 4'h7;
            pin_s2_reg  <= 4'h7;
            pin_s3_reg  <= 4'h7;
            pin_lvl_reg <= 4'h7;
        end else begin
            pin_s1_reg <= pin_raw;
            pin_s2_reg <= pin_s1_reg;
            pin_s3_reg <= pin_s2_reg;
            for (int i = 0; i < 4; i++) begin
                if (pin_s2_reg[i] == pin_s3_reg[i]) pin_lvl_reg[i] <= pin_s3_reg[i];
            end
        end
    end
    logic sync_low, rst_low, sleep_low, cfg_hi;
    assign sync_low  = ~pin_lvl_reg[0];
    assign rst_low   = ~pin_lvl_reg[1];
    assign sleep_low = ~pin_lvl_reg[2];
    assign cfg_hi    = pin_lvl_reg[3];

    // Power-on and pin-reset sequencing
    logic [23:0] por_cnt_reg;
    logic [23:0] prst_cnt_reg;
    logic        soft_rst_reg;
    logic        restore;
    always_ff @(posedge clock) begin
        if (rst) por_cnt_reg <= 24'h000000;
        else if (por_cnt_reg < 24'(POR_RUN)) por_cnt_reg <= por_cnt_reg + 24'h000001;
    end
    always_ff @(posedge clock) begin
        if (rst) prst_cnt_reg <= 24'h000000;
        else if (rst_low) prst_cnt_reg <= cfg_hi ? 24'(RST_NV) : 24'(clk_sync_pkg::RST_FAST_CYC);
        else if (prst_cnt_reg != 24'h000000) prst_cnt_reg <= prst_cnt_reg - 24'h000001;
    end
    assign restore = rst_low || soft_rst_reg;

    // Register file: buffered copies become active on update
    logic [7:0] port_ctl_reg;
    logic [7:0] oc_buf_reg [NOUT];
    logic [7:0] oc_reg     [NOUT];
    logic [7:0] mn_buf_reg [NCH];
    logic [7:0] mn_reg     [NCH];
    logic [7:0] ph_buf_reg [NCH];
    logic [7:0] ph_reg     [NCH];
    logic [7:0] ctl_buf_reg[NCH];
    logic [7:0] ctl_reg    [NCH];
    logic [7:0] dist_buf_reg, dist_reg;
    logic       wr, upd;
    logic [11:0] div_off;
    logic [11:0] out_off;
    assign wr      = link.reg_wr && !restore;
    assign upd     = wr && link.reg_addr == clk_sync_pkg::ADDR_UPDATE && link.reg_wdata[clk_sync_pkg::UPD_BIT];
    assign div_off = link.reg_addr - clk_sync_pkg::ADDR_DIV0;
    assign out_off = link.reg_addr - clk_sync_pkg::ADDR_OUT_CTL0;

    always_ff @(posedge clock) begin
        if (rst || restore) begin
            for (int c = 0; c < NCH; c++) begin
                mn_buf_reg[c]  <= clk_sync_pkg::DIV_MN_RST;
                mn_reg[c]      <= clk_sync_pkg::DIV_MN_RST;
                ctl_buf_reg[c] <= clk_sync_pkg::DIV_CTL_RST;
                ctl_reg[c]     <= clk_sync_pkg::DIV_CTL_RST;
                ph_buf_reg[c]  <= clk_sync_pkg::DIV_PH_RST;
                ph_reg[c]      <= clk_sync_pkg::DIV_PH_RST;
            end
            for (int k = 0; k < NOUT; k++) begin
                oc_buf_reg[k] <= clk_sync_pkg::OUT_CTL_RST;
                oc_reg[k]     <= clk_sync_pkg::OUT_CTL_RST;
            end
            dist_buf_reg <= clk_sync_pkg::DIST_RST;
            dist_reg     <= clk_sync_pkg::DIST_RST;
            if (!rst && cfg_hi) begin
                // Stored settings are the phase words; the rest are defaults
                for (int c = 0; c < NCH; c++) begin
                    ph_buf_reg[c] <= {3'b000, NV_PHASE[c*5 +: 5]};
                    ph_reg[c]     <= {3'b000, NV_PHASE[c*5 +: 5]};
                end
            end
        end else begin
            if (wr && in_block(link.reg_addr, clk_sync_pkg::ADDR_OUT_CTL0, NOUT)) begin
                oc_buf_reg[out_off[3:0]] <= link.reg_wdata;
            end
            if (wr && in_block(link.reg_addr, clk_sync_pkg::ADDR_DIV0, 3 * NCH)) begin
                case (div_off % clk_sync_pkg::DIV_STRIDE)
                    12'h000: mn_buf_reg[2'(div_off / clk_sync_pkg::DIV_STRIDE)] <= link.reg_wdata;
                    12'h001: ph_buf_reg[2'(div_off / clk_sync_pkg::DIV_STRIDE)] <= link.reg_wdata;
                    default: ctl_buf_reg[2'(div_off / clk_sync_pkg::DIV_STRIDE)] <= link.reg_wdata;
                endcase
            end
            if (wr && link.reg_addr == clk_sync_pkg::ADDR_DIST) dist_buf_reg <= link.reg_wdata;
            if (upd) begin
                dist_reg <= dist_buf_reg;
                for (int c = 0; c < NCH; c++) begin
                    mn_reg[c]  <= mn_buf_reg[c];
                    ph_reg[c]  <= ph_buf_reg[c];
                    ctl_reg[c] <= ctl_buf_reg[c];
                end
                for (int k = 0; k < NOUT; k++) begin
                    oc_reg[k] <= oc_buf_reg[k];
                    // Entering single-ended mode switches both halves on
                    if (oc_buf_reg[k][clk_sync_pkg::OUT_SE_BIT] && !oc_reg[k][clk_sync_pkg::OUT_SE_BIT]) begin
                        oc_reg[k][clk_sync_pkg::OUT_ENA_BIT] <= 1'b1;
                        oc_reg[k][clk_sync_pkg::OUT_ENB_BIT] <= 1'b1;
                    end
                end
            end
        end
    end

    // Soft reset: bits 2 and 5 of port control; ends on the next port tick
    logic srst_req;
    assign srst_req = link.reg_wr && link.reg_addr == clk_sync_pkg::ADDR_PORT_CTL
                      && link.reg_wdata[clk_sync_pkg::PORT_SRST_LO] && link.reg_wdata[clk_sync_pkg::PORT_SRST_HI];
    always_ff @(posedge clock) begin
        if (rst) begin
            soft_rst_reg <= 1'b0;
            port_ctl_reg <= clk_sync_pkg::PORT_RST;
        end else if (srst_req) begin
            soft_rst_reg <= 1'b1;
        end else if (link.port_tick) begin
            soft_rst_reg <= 1'b0;
        end else if (wr && link.reg_addr == clk_sync_pkg::ADDR_PORT_CTL) begin
            port_ctl_reg <= link.reg_wdata;
        end
    end

    // Any of these held high is one sync operation; its fall ends it
    logic hold_all, por_dark;
    assign hold_all = sync_low || sleep_low || restore || prst_cnt_reg != 24'h000000
                      || por_cnt_reg < 24'(POR_SYNC) || soft_rst_reg
                      || dist_reg[clk_sync_pkg::DIST_SYNC_BIT] || dist_reg[clk_sync_pkg::DIST_PD_BIT];
    assign por_dark = por_cnt_reg < 24'(POR_RUN);

    always_ff @(posedge clock) begin
        if (rst) link.busy <= 1'b1;
        else link.busy <= hold_all;
    end

    // Channel dividers: high N+1 cycles, low M+1 cycles
    logic [3:0] ch_lvl;
    for (genvar c = 0; c < NCH; c++) begin : g_ch
        clk_sync_pkg::ch_state_t st_reg;
        logic [7:0] cnt_reg;
        logic       lvl_reg;
        logic [4:0] phi;
        logic [7:0] delay;
        assign phi   = {ph_reg[c][clk_sync_pkg::PH_SH_BIT], ph_reg[c][3:0]};
        assign delay = phi[4] ? 8'({4'h0, phi[3:0]} + {4'h0, mn_reg[c][7:4]} + 8'h01)
                              : 8'({3'b000, phi});
        always_ff @(posedge clock) begin
            if (rst) begin
                st_reg  <= clk_sync_pkg::CH_HOLD;
                cnt_reg <= 8'h00;
                lvl_reg <= 1'b0;
            end else if (hold_all && !ctl_reg[c][clk_sync_pkg::CTL_IGN_BIT]) begin
                st_reg  <= clk_sync_pkg::CH_HOLD;
                lvl_reg <= ph_reg[c][clk_sync_pkg::PH_SH_BIT];
                cnt_reg <= 8'h00;
            end else begin
                case (st_reg)
                    clk_sync_pkg::CH_HOLD: begin
                        st_reg  <= clk_sync_pkg::CH_DELAY;
                        cnt_reg <= 8'(8'(clk_sync_pkg::SYNC_PIPE_CYC) + delay);
                    end
                    clk_sync_pkg::CH_DELAY: begin
                        if (cnt_reg == 8'h00) begin
                            st_reg  <= clk_sync_pkg::CH_RUN;
                            lvl_reg <= 1'b1;
                            cnt_reg <= {4'h0, mn_reg[c][3:0]};
                        end else begin
                            cnt_reg <= cnt_reg - 8'h01;
                        end
                    end
                    clk_sync_pkg::CH_RUN: begin
                        if (cnt_reg == 8'h00) begin
                            lvl_reg <= ~lvl_reg;
                            cnt_reg <= lvl_reg ? {4'h0, mn_reg[c][7:4]} : {4'h0, mn_reg[c][3:0]};
                        end else begin
                            cnt_reg <= cnt_reg - 8'h01;
                        end
                    end
                    default: st_reg <= clk_sync_pkg::CH_HOLD;
                endcase
            end
        end
        assign ch_lvl[c] = lvl_reg;
        always_ff @(posedge clock) begin
            if (rst) ch_running[c] <= 1'b0;
            else ch_running[c] <= st_reg == clk_sync_pkg::CH_RUN && !ctl_reg[c][clk_sync_pkg::CTL_CHPD_BIT];
        end
    end

    // Output drivers; three per channel
    for (genvar k = 0; k < NOUT; k++) begin : g_out
        logic lvl, dark, se;
        assign lvl  = ch_lvl[k / clk_sync_pkg::OUTS_PER_CH];
        assign dark = por_dark || sleep_low || restore || dist_reg[clk_sync_pkg::DIST_PD_BIT]
                      || ctl_reg[k / clk_sync_pkg::OUTS_PER_CH][clk_sync_pkg::CTL_CHPD_BIT];
        assign se   = oc_reg[k][clk_sync_pkg::OUT_SE_BIT];
        always_ff @(posedge clock) begin
            if (rst) begin
                diff_out[k]  <= 1'b0;
                diff_oe_n[k] <= 1'b1;
                se_a[k]      <= 1'b0;
                se_a_oe_n[k] <= 1'b1;
                se_b[k]      <= 1'b0;
                se_b_oe_n[k] <= 1'b1;
            end else begin
                diff_out[k]  <= lvl ^ oc_reg[k][clk_sync_pkg::OUT_INV_BIT];
                diff_oe_n[k] <= dark || se || oc_reg[k][clk_sync_pkg::OUT_PD_BIT];
                se_a[k]      <= lvl ^ oc_reg[k][clk_sync_pkg::OUT_POLA_BIT];
                se_b[k]      <= lvl ^ oc_reg[k][clk_sync_pkg::OUT_POLB_BIT];
                se_a_oe_n[k] <= dark || !se || !oc_reg[k][clk_sync_pkg::OUT_ENA_BIT];
                se_b_oe_n[k] <= dark || !se || !oc_reg[k][clk_sync_pkg::OUT_ENB_BIT];
            end
        end
    end
endmodule // clk_sync_device
`default_nettype wire

//--- clk_sync_pkg.sv
// Shared constants for the output sync and reset controller
package clk_sync_pkg;
    localparam int NUM_CH      = 4;
    localparam int OUTS_PER_CH = 3;
    localparam int NUM_OUT     = 12;
    // Device register addresses
    localparam logic [11:0] ADDR_PORT_CTL = 12'h000;
    localparam logic [11:0] ADDR_OUT_CTL0 = 12'h0f0;
    localparam logic [11:0] ADDR_DIV0     = 12'h190;
    localparam logic [11:0] ADDR_DIST     = 12'h230;
    localparam logic [11:0] ADDR_UPDATE   = 12'h232;
    localparam logic [11:0] DIV_STRIDE    = 12'h003;
    // Field positions
    localparam int PORT_SRST_LO  = 2;
    localparam int PORT_SRST_HI  = 5;
    localparam int OUT_PD_BIT    = 0;
    localparam int OUT_INV_BIT   = 1;
    localparam int OUT_SE_BIT    = 2;
    localparam int OUT_POLA_BIT  = 3;
    localparam int OUT_POLB_BIT  = 4;
    localparam int OUT_ENA_BIT   = 5;
    localparam int OUT_ENB_BIT   = 6;
    localparam int PH_SH_BIT     = 4;
    localparam int CTL_CHPD_BIT  = 2;
    localparam int CTL_IGN_BIT   = 6;
    localparam int DIST_SYNC_BIT = 0;
    localparam int DIST_PD_BIT   = 1;
    localparam int UPD_BIT       = 0;
    // Reset values
    localparam logic [7:0] OUT_CTL_RST = 8'h00;
    localparam logic [7:0] DIV_MN_RST  = 8'h00;
    localparam logic [7:0] DIV_PH_RST  = 8'h00;
    localparam logic [7:0] DIV_CTL_RST = 8'h00;
    localparam logic [7:0] DIST_RST    = 8'h00;
    localparam logic [7:0] PORT_RST    = 8'h00;
    // Timing
    localparam int CLK_HZ        = 10_000_000;
    localparam int SYNC_PIPE_CYC = 14;
    localparam int POR_SYNC_MS   = 50;
    localparam int POR_RUN_MS    = 70;
    localparam int RST_FAST_US   = 2;
    localparam int RST_NV_MS     = 20;
    localparam int POR_SYNC_CYC  = POR_SYNC_MS * (CLK_HZ / 1000);
    localparam int POR_RUN_CYC   = POR_RUN_MS * (CLK_HZ / 1000);
    localparam int RST_FAST_CYC  = RST_FAST_US * (CLK_HZ / 1_000_000);
    localparam int RST_NV_CYC    = RST_NV_MS * (CLK_HZ / 1000);
    // Host AHB register map
    localparam logic [7:0] HOST_PINS = 8'h00;
    localparam logic [7:0] HOST_CMD  = 8'h04;
    localparam logic [7:0] HOST_STAT = 8'h08;
    localparam int PIN_SYNC_BIT  = 0;
    localparam int PIN_RESET_BIT = 1;
    localparam int PIN_SLEEP_BIT = 2;
    localparam int PIN_CFG_BIT   = 3;
    localparam logic [3:0] PINS_RST = 4'h7;
    localparam int CMD_TICK_BIT  = 31;
    typedef enum logic [2:0] {
        CH_HOLD  = 3'b001,
        CH_DELAY = 3'b010,
        CH_RUN   = 3'b100
    } ch_state_t;
endpackage

//--- clk_sync_if.sv
// Pins and register write port between host controller and clock device
`timescale 1ns/1ps
`default_nettype none
interface clk_sync_if;
    logic        sync_n;
    logic        reset_n;
    logic        sleep_n;
    logic        cfg_src;
    logic        reg_wr;
    logic [11:0] reg_addr;
    logic [7:0]  reg_wdata;
    logic        port_tick;
    logic        busy;
    modport device (input sync_n, reset_n, sleep_n, cfg_src, reg_wr, reg_addr, reg_wdata, port_tick,
                    output busy);
    modport host (output sync_n, reset_n, sleep_n, cfg_src, reg_wr, reg_addr, reg_wdata, port_tick,
                  input busy);
endinterface
`default_nettype wire

//--- clk_sync_host.sv
// Host controller end: AHB-Lite registers driving the device pins and write port
`timescale 1ns/1ps
`default_nettype none
module clk_sync_host (
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    clk_sync_if.host         link
);
    logic       wr_pend_reg;
    logic [7:0] wr_addr_reg;
    logic [3:0] pins_reg;
    logic       take;
    assign take = hsel && hready && htrans[1];

    // Zero wait states: reads are registered in the address phase
    always_ff @(posedge clock) begin
        if (rst) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
            hrdata      <= 32'h00000000;
            hreadyout   <= 1'b1;
            hresp       <= 1'b0;
        end else begin
            hreadyout   <= 1'b1;
            hresp       <= 1'b0;
            wr_pend_reg <= take && hwrite && hsize == 3'h2;
            wr_addr_reg <= haddr[7:0];
            if (take && !hwrite) begin
                case (haddr[7:0])
                    clk_sync_pkg::HOST_PINS: hrdata <= {28'h0000000, pins_reg};
                    clk_sync_pkg::HOST_STAT: hrdata <= {31'h00000000, link.busy};
                    default:                 hrdata <= 32'h00000000;
                endcase
            end
        end
    end

    // Pin levels; sync low then high is a manual alignment
    always_ff @(posedge clock) begin
        if (rst) pins_reg <= clk_sync_pkg::PINS_RST;
        else if (wr_pend_reg && wr_addr_reg == clk_sync_pkg::HOST_PINS) pins_reg <= hwdata[3:0];
    end
    assign link.sync_n  = pins_reg[clk_sync_pkg::PIN_SYNC_BIT];
    assign link.reset_n = pins_reg[clk_sync_pkg::PIN_RESET_BIT];
    assign link.sleep_n = pins_reg[clk_sync_pkg::PIN_SLEEP_BIT];
    assign link.cfg_src = pins_reg[clk_sync_pkg::PIN_CFG_BIT];

    // One command word: either a register write or a single port clock
    always_ff @(posedge clock) begin
        if (rst) begin
            link.reg_wr    <= 1'b0;
            link.port_tick <= 1'b0;
            link.reg_addr  <= 12'h000;
            link.reg_wdata <= 8'h00;
        end else begin
            link.reg_wr    <= 1'b0;
            link.port_tick <= 1'b0;
            if (wr_pend_reg && wr_addr_reg == clk_sync_pkg::HOST_CMD) begin
                if (hwdata[clk_sync_pkg::CMD_TICK_BIT]) begin
                    link.port_tick <= 1'b1;
                end else begin
                    link.reg_wr    <= 1'b1;
                    link.reg_addr  <= hwdata[19:8];
                    link.reg_wdata <= hwdata[7:0];
                end
            end
        end
    end
endmodule // clk_sync_host
`default_nettype wire

//--- clk_sync_checker.sv
// Assertions on the pin and register link between host and device
`timescale 1ns/1ps
`default_nettype none
module clk_sync_checker #(
    parameter int POR_SYNC = 20,
    parameter int RST_NV   = 30
) (
    input wire logic        clock,
    input wire logic        rst,
    input wire logic        sync_n,
    input wire logic        reset_n,
    input wire logic        sleep_n,
    input wire logic        cfg_src,
    input wire logic        reg_wr,
    input wire logic [11:0] reg_addr,
    input wire logic [7:0]  reg_wdata,
    input wire logic        port_tick,
    input wire logic        busy
);
    // Generous settle time: covers power-on, stored-settings load and the sync pipeline
    localparam int QUIET = POR_SYNC + RST_NV + 60;
    localparam int NV_SEEN = RST_NV - 2;
    logic [7:0]  dist_buf_reg;
    logic [1:0]  dist_act_reg;
    logic        srst_reg;
    logic [3:0]  age_reg;
    logic [15:0] calm_reg;
    logic        wr_ok;
    logic        srst_wr;
    logic        upd_wr;
    assign srst_wr = reg_wr && reg_addr == clk_sync_pkg::ADDR_PORT_CTL && reg_wdata[2] && reg_wdata[5];
    assign wr_ok = reg_wr && reset_n && !srst_reg;
    assign upd_wr = wr_ok && reg_addr == clk_sync_pkg::ADDR_UPDATE && reg_wdata[0];
    always_ff @(posedge clock) begin
        if (rst || !reset_n || srst_wr) begin
            dist_buf_reg <= 8'h00;
            dist_act_reg <= 2'h0;
        end else begin
            if (wr_ok && reg_addr == clk_sync_pkg::ADDR_DIST)
                dist_buf_reg <= reg_wdata;
            if (upd_wr)
                dist_act_reg <= dist_buf_reg[1:0];
        end
    end
    always_ff @(posedge clock) begin
        if (rst || port_tick)
            srst_reg <= 1'b0;
        else if (srst_wr)
            srst_reg <= 1'b1;
    end
    always_ff @(posedge clock) begin
        if (!srst_reg)
            age_reg <= 4'h0;
        else if (age_reg != 4'hf)
            age_reg <= age_reg + 4'h1;
    end
    always_ff @(posedge clock) begin
        if (rst || !sync_n || !reset_n || !sleep_n || srst_reg || srst_wr || upd_wr || dist_act_reg != 2'h0)
            calm_reg <= 16'h0000;
        else if (calm_reg != QUIET[15:0])
            calm_reg <= calm_reg + 16'h0001;
    end
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    pin_sync_hold_a: assert property ((!sync_n) [*6] |-> busy)
        else $error("busy low while align pin held");
    sleep_hold_a: assert property ((!sleep_n) [*6] |-> busy)
        else $error("busy low while sleep pin held");
    reset_hold_a: assert property ((!reset_n) [*6] |-> busy)
        else $error("busy low while reset pin held");
    pin_filter_a: assert property (!busy && $fell(sync_n) |=> !busy)
        else $error("align pin acted on without synchronizer delay");
    quiet_release_a: assert property (calm_reg == QUIET[15:0] |-> !busy)
        else $error("hold persists with no sync source");
    soft_reset_hold_a: assert property (srst_wr && reset_n |-> ##[1:3] busy)
        else $error("soft reset did not hold outputs");
    soft_reset_wait_a: assert property (srst_reg && age_reg >= 4'h4 |-> busy)
        else $error("soft reset ended without port tick");
    soft_sync_a: assert property (upd_wr && dist_buf_reg[1:0] != 2'h0 |-> ##[1:6] busy)
        else $error("update with sync bit set gave no hold");
    nv_reset_hold_a: assert property ($rose(reset_n) && cfg_src |-> ##NV_SEEN busy)
        else $error("stored-settings reset ended early");
endmodule // clk_sync_checker
`default_nettype wire

//--- testbench.sv
// Host and device joined by the link, driven over AHB-Lite
`timescale 1ns/1ps
`default_nettype none
module testbench;
    typedef struct {logic [3:0] pins; int wt; logic cb; logic bz; logic [3:0] run;} row_t;
    logic        clock, rst, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [11:0] diff_out, diff_oe_n, se_a_oe_n, se_b_oe_n, se_a, se_b;
    logic [3:0]  ch_running;
    int          fails, n_tests, cycles, tg, r0;
    int          fall[3];
    logic [2:0]  prev;
    row_t        rows[10] = '{'{4'h6, 10, 1, 1, 4'h0}, '{4'h7, 80, 1, 0, 4'hf}, '{4'h3, 10, 1, 1, 4'h0},
        '{4'h7, 80, 1, 0, 4'hf}, '{4'h5, 10, 1, 1, 4'h0}, '{4'h7, 80, 1, 0, 4'hf}, '{4'hd, 10, 1, 1, 4'h0},
        '{4'hf, 15, 0, 0, 4'h0}, '{4'hf, 80, 1, 0, 4'hf}, '{4'h7, 10, 1, 0, 4'hf}};
    clk_sync_if clk_sync_if_inst();
    clk_sync_host clk_sync_host_inst(.clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .link(clk_sync_if_inst));
    clk_sync_device #(.POR_SYNC(20), .POR_RUN(40), .RST_NV(30)) clk_sync_device_inst(.clock(clock), .rst(rst),
        .link(clk_sync_if_inst), .diff_out(diff_out), .diff_oe_n(diff_oe_n), .se_a(se_a), .se_a_oe_n(se_a_oe_n),
        .se_b(se_b), .se_b_oe_n(se_b_oe_n), .ch_running(ch_running));
    clk_sync_checker #(.POR_SYNC(20), .RST_NV(30)) clk_sync_checker_inst(.clock(clock), .rst(rst),
        .sync_n(clk_sync_if_inst.sync_n), .reset_n(clk_sync_if_inst.reset_n), .sleep_n(clk_sync_if_inst.sleep_n),
        .cfg_src(clk_sync_if_inst.cfg_src), .reg_wr(clk_sync_if_inst.reg_wr), .reg_addr(clk_sync_if_inst.reg_addr),
        .reg_wdata(clk_sync_if_inst.reg_wdata), .port_tick(clk_sync_if_inst.port_tick), .busy(clk_sync_if_inst.busy));
    task automatic tally_and_finish;
        if (fails == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // Single word transfer; waits on hready in both phases, no fixed latency assumed
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge clock); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clock); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic dev_wr(input logic [11:0] a, input logic [7:0] d);
        ahb(1'b1, clk_sync_pkg::HOST_CMD, {12'h000, a, d});
    endtask
    task automatic upd_wait(input int n);
        dev_wr(clk_sync_pkg::ADDR_UPDATE, 8'h01);
        repeat (n) @(posedge clock);
    endtask
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            tally_and_finish;
        end
    end
    initial begin
        {rst, hsel, hwrite, htrans, haddr, hwdata} = {1'b1, 68'h0};
        hsize = 3'h2;
        repeat (8) @(posedge clock);
        rst <= 1'b0;
        ahb(1'b0, clk_sync_pkg::HOST_STAT, 32'h0);
        chk("por busy", 32'h1, {31'h0, rd[0]});
        ahb(1'b0, clk_sync_pkg::HOST_PINS, 32'h0);
        chk("pins reset", 32'h7, rd);
        ahb(1'b0, 8'h0c, 32'h0);
        chk("unmapped read", 32'h0, rd);
        repeat (60) @(posedge clock);
        chk("por running", 32'hf, {28'h0, ch_running});
        foreach (rows[i]) begin
            ahb(1'b1, clk_sync_pkg::HOST_PINS, {28'h0, rows[i].pins});
            repeat (rows[i].wt) @(posedge clock);
            ahb(1'b0, clk_sync_pkg::HOST_STAT, 32'h0);
            if (rows[i].cb)
                chk("row busy", {31'h0, rows[i].bz}, {31'h0, rd[0]});
            chk("row running", {28'h0, rows[i].run}, {28'h0, ch_running});
        end
        dev_wr(clk_sync_pkg::ADDR_DIV0 + 12'h004, 8'h05);
        dev_wr(clk_sync_pkg::ADDR_DIV0 + 12'h006, 8'h20);
        dev_wr(clk_sync_pkg::ADDR_DIV0 + 12'h007, 8'h11);
        dev_wr(clk_sync_pkg::ADDR_DIV0 + 12'h00b, 8'h40);
        upd_wait(4);
        ahb(1'b1, clk_sync_pkg::HOST_PINS, 32'h6);
        repeat (10) @(posedge clock);
        tg = 0;
        for (int i = 0; i < 10; i++) begin
            prev[0] = diff_out[9];
            @(posedge clock);
            if (diff_out[9] !== prev[0])
                tg++;
        end
        chk("ignored toggles", 32'h1, {31'h0, tg != 0});
        chk("preset levels", 32'h1c0, {23'h0, diff_out[8:0]});
        ahb(1'b1, clk_sync_pkg::HOST_PINS, 32'h7);
        fall = '{-1, -1, -1};
        r0 = -1;
        prev = 3'h4;
        for (int i = 0; i < 60; i++) begin
            @(posedge clock);
            for (int k = 0; k < 3; k++) begin
                if (fall[k] < 0 && prev[k] === 1'b1 && diff_out[3 * k] === 1'b0)
                    fall[k] = i;
                prev[k] = diff_out[3 * k];
            end
            if (r0 < 0 && diff_out[0] === 1'b1)
                r0 = i;
        end
        chk("restart delay", 32'h1, {31'h0, r0 >= 15 && r0 <= 22});
        chk("low offset", 32'd5, fall[1] - fall[0]);
        chk("high offset", 32'd4, fall[2] - fall[0]);
        dev_wr(clk_sync_pkg::ADDR_OUT_CTL0 + 12'h001, 8'h02);
        dev_wr(clk_sync_pkg::ADDR_OUT_CTL0 + 12'h002, 8'h01);
        dev_wr(clk_sync_pkg::ADDR_OUT_CTL0 + 12'h004, 8'h04);
        upd_wait(4);
        chk("invert", 32'h1, {31'h0, diff_out[1] === ~diff_out[0]});
        chk("out pd", 32'h1, {31'h0, diff_oe_n[2]});
        chk("se both on", 32'h0, {30'h0, se_a_oe_n[4], se_b_oe_n[4]});
        dev_wr(clk_sync_pkg::ADDR_OUT_CTL0 + 12'h004, 8'h2c);
        upd_wait(4);
        chk("se b off", 32'h1, {30'h0, se_a_oe_n[4], se_b_oe_n[4]});
        chk("se pol", 32'h1, {31'h0, se_a[4] !== diff_out[3] && se_b[4] === diff_out[3]});
        for (int b = 1; b < 3; b++) begin
            dev_wr(clk_sync_pkg::ADDR_DIST, b[7:0]);
            repeat (8) @(posedge clock);
            ahb(1'b0, clk_sync_pkg::HOST_STAT, 32'h0);
            chk("no update", 32'h0, {31'h0, rd[0]});
            upd_wait(8);
            ahb(1'b0, clk_sync_pkg::HOST_STAT, 32'h0);
            chk("sync bit hold", 32'h1, {31'h0, rd[0]});
            dev_wr(clk_sync_pkg::ADDR_DIST, 8'h00);
            upd_wait(60);
            ahb(1'b0, clk_sync_pkg::HOST_STAT, 32'h0);
            chk("sync bit done", 32'h0, {31'h0, rd[0]});
        end
        dev_wr(clk_sync_pkg::ADDR_PORT_CTL, 8'h24);
        repeat (40) @(posedge clock);
        ahb(1'b0, clk_sync_pkg::HOST_STAT, 32'h0);
        chk("soft reset hold", 32'h1, {31'h0, rd[0]});
        chk("soft reset dark", 32'hfff, {20'h0, diff_oe_n});
        ahb(1'b1, clk_sync_pkg::HOST_CMD, 32'h80000000);
        repeat (80) @(posedge clock);
        ahb(1'b0, clk_sync_pkg::HOST_STAT, 32'h0);
        chk("soft reset done", 32'h0, {31'h0, rd[0]});
        chk("defaults back", 32'h0, {31'h0, diff_oe_n[2]});
        chk("all running", 32'hf, {28'h0, ch_running});
        tally_and_finish;
    end
endmodule // testbench
`default_nettype wire
